// File: design/ftv_video_out.sv
// Four-tap line video formatter driving two serializer inputs.
// Functional notes
// - 12-bit: four 12-bit pixels plus flags.
// - Launch outputs on pixel clock rising edges.
// - Data valid only when both flags high.
// - 10-bit mode drops two low bits.
// - 8-bit mode drops four low bits.
// - Flags low whenever no valid data, except an underrun launch, which keeps them high over stale buffer data.
// - Start line only after readout completes.
// - First beat: both flags rise, pixels 1-4.
// - Each next beat advances four pixels.
// - Flags fall together after last beat.
// - 12-bit first serializer port bit layout.
// - 10-bit first serializer layout, rest unused.
// - Second serializer layout for stream two, three.
// - Line length by model, halved when binning.
`timescale 1ns/1ps
`default_nettype none
module ftv_video_out #(
    parameter int unsigned LINE_PIXELS = ftv_pkg::LINE_PIXELS_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic pclk_i,
    input wire logic readout_done_i,
    input wire logic [1:0] bit_depth_i,
    input wire logic binning_i,
    input wire logic beat_valid_i,
    output logic beat_ready_o,
    input wire logic [ftv_pkg::BEAT_W-1:0] beat_data_i,
    output logic [ftv_pkg::TX_W-1:0] tx_x_data_o,
    output logic tx_x_lval_o,
    output logic tx_x_fval_o,
    output logic tx_x_dval_o,
    output logic tx_x_spare_o,
    output logic tx_x_strobe_o,
    output logic [ftv_pkg::TX_W-1:0] tx_y_data_o,
    output logic tx_y_lval_o,
    output logic tx_y_fval_o,
    output logic tx_y_dval_o,
    output logic tx_y_spare_o,
    output logic tx_y_strobe_o,
    output logic underrun_o
);
    localparam int unsigned PW = ftv_pkg::PIX_W;
    localparam int unsigned CW = ftv_pkg::CNT_W;
    localparam int unsigned TW = ftv_pkg::TX_W;
    // Beats per line without and with binning.
    localparam logic [CW-1:0] BEATS_FULL = CW'(LINE_PIXELS / ftv_pkg::TAPS);
    localparam logic [CW-1:0] BEATS_BIN = CW'(LINE_PIXELS / 8);

    //////////////////////////////////////////////////////////////////////
    // Formatting functions.
    //////////////////////////////////////////////////////////////////////

    // Reduces a converter result to the selected depth, right aligned.
    function automatic logic [PW-1:0] ftv_trim(input logic [1:0] depth,
                                               input logic [PW-1:0] pix);
        logic [PW-1:0] res;
        res = pix;
        if (depth == ftv_pkg::DEPTH_10) begin
            res = {2'h0, pix[11:2]};
        end else if (depth == ftv_pkg::DEPTH_8) begin
            res = {4'h0, pix[11:4]};
        end
        return res;
    endfunction

    // Lays two streams, or three in 8-bit mode, out on three 8-bit ports as the depth demands.
    function automatic logic [TW-1:0] ftv_pack(input logic [1:0] depth,
                                               input logic [PW-1:0] lo,
                                               input logic [PW-1:0] hi,
                                               input logic [PW-1:0] third);
        logic [TW-1:0] res;
        res = {hi[7:0], hi[11:8], lo[11:8], lo[7:0]};
        if (depth == ftv_pkg::DEPTH_10) begin
            res = {hi[7:0], 2'h0, hi[9:8], 2'h0, lo[9:8], lo[7:0]};
        end else if (depth == ftv_pkg::DEPTH_8) begin
            res = {third[7:0], hi[7:0], lo[7:0]};
        end
        return res;
    endfunction

    //////////////////////////////////////////////////////////////////////
    // Pixel clock sampling and beat buffer.
    //////////////////////////////////////////////////////////////////////

    // Synchronised pixel clock level and its previous value.
    logic pclk_sync;
    logic pclk_prev_reg;
    // One-cycle pulse on each rising edge of the pixel clock.
    wire logic pclk_rise = pclk_sync && !pclk_prev_reg;

    ftv_sync #(
        .WIDTH(1)
    ) u_pclk_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i(pclk_i),
        .sync_o(pclk_sync)
    );

    // Buffered beat towards the link.
    logic buf_valid;
    logic [ftv_pkg::BEAT_W-1:0] buf_data;
    // Buffer pop, one per launched beat while the buffer holds one.
    wire logic buf_pop;

    ftv_buf #(
        .WIDTH(ftv_pkg::BEAT_W),
        .DEPTH(ftv_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_valid_i(beat_valid_i),
        .in_ready_o(beat_ready_o),
        .in_data_i(beat_data_i),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_pop),
        .out_data_o(buf_data)
    );

    //////////////////////////////////////////////////////////////////////
    // Line sequencing.
    //////////////////////////////////////////////////////////////////////

    // Sequencer state.
    ftv_pkg::ftv_state_t state_reg;
    ftv_pkg::ftv_state_t state_next;
    // Readout completed and a line is waiting to be sent.
    logic pending_reg;
    // Beats already sent in the current line.
    logic [CW-1:0] cnt_reg;
    // Depth and beat count latched for the whole line.
    logic [1:0] depth_reg;
    logic [CW-1:0] beats_reg;
    // Launched flag and data registers.
    logic valid_reg;
    logic [TW-1:0] x_data_reg;
    logic [TW-1:0] y_data_reg;
    logic strobe_reg;
    logic underrun_reg;

    // Line starts only once readout is done and the first beat is held.
    wire logic start = (state_reg == ftv_pkg::FTV_WAIT) && pclk_rise &&
                       pending_reg && buf_valid;
    // Last beat has gone out; the next edge ends the line.
    wire logic line_done = (cnt_reg == beats_reg);
    wire logic advance = (state_reg == ftv_pkg::FTV_LINE) && pclk_rise &&
                         !line_done;
    wire logic finish = (state_reg == ftv_pkg::FTV_LINE) && pclk_rise &&
                        line_done;
    wire logic launch = start || advance;
    assign buf_pop = launch && buf_valid;
    // Depth used at this launch: fresh on the first beat, then latched.
    wire logic [1:0] depth_use = start ? bit_depth_i : depth_reg;
    wire logic [PW-1:0] s0 = ftv_trim(depth_use, buf_data[11:0]);
    wire logic [PW-1:0] s1 = ftv_trim(depth_use, buf_data[23:12]);
    wire logic [PW-1:0] s2 = ftv_trim(depth_use, buf_data[35:24]);
    wire logic [PW-1:0] s3 = ftv_trim(depth_use, buf_data[47:36]);
    wire logic is8 = (depth_use == ftv_pkg::DEPTH_8);
    wire logic [TW-1:0] x_next = ftv_pack(depth_use, s0, s1, s2);
    // Port D holds stream three's low byte and port F the mixed high bits.
    wire logic [TW-1:0] y_pack = ftv_pack(depth_use, s2, s3, s3);
    wire logic [TW-1:0] y_full = {y_pack[15:8], y_pack[7:0], y_pack[23:16]};
    // In 8-bit mode the second serializer carries stream three only.
    wire logic [TW-1:0] y_next = is8 ? {16'h0000, s3[7:0]} : y_full;

    // Next state: wait for a ready line, then run for its beat count.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ftv_pkg::FTV_WAIT: begin
                if (start) begin
                    state_next = ftv_pkg::FTV_LINE;
                end
            end
            ftv_pkg::FTV_LINE: begin
                if (finish) begin
                    state_next = ftv_pkg::FTV_WAIT;
                end
            end
            default: begin
                state_next = ftv_pkg::FTV_WAIT;
            end
        endcase
    end

    // State, edge history and the readout flag; a new readout wins.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ftv_pkg::FTV_WAIT;
            pclk_prev_reg <= 1'b0;
            pending_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pclk_prev_reg <= pclk_sync;
            if (readout_done_i) begin
                pending_reg <= 1'b1;
            end else if (start) begin
                pending_reg <= 1'b0;
            end
        end
    end

    // Beat counter and per-line settings, loaded at the line start.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            depth_reg <= ftv_pkg::DEPTH_12;
            beats_reg <= BEATS_FULL;
        end else if (start) begin
            cnt_reg <= CW'(1);
            depth_reg <= bit_depth_i;
            beats_reg <= binning_i ? BEATS_BIN : BEATS_FULL;
        end else if (advance) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // Flags and data change only at pixel clock rising edges; idle data is low.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            valid_reg <= 1'b0;
            x_data_reg <= '0;
            y_data_reg <= '0;
        end else if (launch) begin
            valid_reg <= 1'b1;
            x_data_reg <= x_next;
            y_data_reg <= y_next;
        end else if (finish) begin
            valid_reg <= 1'b0;
            x_data_reg <= '0;
            y_data_reg <= '0;
        end
    end

    // Strobe follows the sampled pixel clock; underrun marks a late beat.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_reg <= 1'b0;
            underrun_reg <= 1'b0;
        end else begin
            strobe_reg <= pclk_sync;
            if (launch && !buf_valid) begin
                underrun_reg <= 1'b1;
            end else if (start) begin
                underrun_reg <= 1'b0;
            end
        end
    end

    // Both flags share one register so they always move together.
    assign tx_x_lval_o = valid_reg;
    assign tx_x_dval_o = valid_reg;
    assign tx_y_lval_o = valid_reg;
    assign tx_y_dval_o = valid_reg;
    assign tx_x_fval_o = 1'b0;
    assign tx_x_spare_o = 1'b0;
    assign tx_y_fval_o = 1'b0;
    assign tx_y_spare_o = 1'b0;
    assign tx_x_strobe_o = strobe_reg;
    assign tx_y_strobe_o = strobe_reg;
    assign tx_x_data_o = x_data_reg;
    assign tx_y_data_o = y_data_reg;
    assign underrun_o = underrun_reg;

    //////////////////////////////////////////////////////////////////////
    // Checks.
    //////////////////////////////////////////////////////////////////////

    // Length of the run of high flags, for the line length check.
    logic [CW:0] run_reg;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            run_reg <= '0;
        end else if (!valid_reg) begin
            run_reg <= '0;
        end else if (pclk_rise) begin
            run_reg <= run_reg + 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_flag_edge_launch: assert property (
        $changed(valid_reg) |-> $past(pclk_rise))
        else $error("Flags changed away from a pixel clock edge.");
    a_start_after_readout: assert property (
        $rose(valid_reg) |-> $past(pending_reg))
        else $error("Line started before readout completed.");
    a_idle_data_low: assert property (
        !valid_reg |-> (x_data_reg == '0) && (y_data_reg == '0))
        else $error("Data not low while flags are low.");
    a_first_pixels: assert property (
        start && (bit_depth_i == ftv_pkg::DEPTH_12) |=>
        valid_reg && (x_data_reg[7:0] == $past(buf_data[7:0])) &&
        (y_data_reg[7:0] == $past(buf_data[43:36])))
        else $error("First beat does not carry pixels one to four.");
    a_line_length: assert property (
        $fell(valid_reg) |-> run_reg == {1'b0, beats_reg})
        else $error("Line did not last its beat count.");
    a_fall_after_last: assert property (
        valid_reg && line_done && pclk_rise |=> !valid_reg)
        else $error("Flags stayed high after the last beat.");
    a_depth10_unused: assert property (
        valid_reg && (depth_reg == ftv_pkg::DEPTH_10) |->
        (x_data_reg[11:10] == 2'h0) && (x_data_reg[15:14] == 2'h0))
        else $error("Unused 10-bit positions not low.");
    a_depth8_unused: assert property (
        valid_reg && (depth_reg == ftv_pkg::DEPTH_8) |->
        (y_data_reg[23:8] == 16'h0000))
        else $error("Unused 8-bit positions not low.");
    a_depth8_trim: assert property (
        advance && (depth_reg == ftv_pkg::DEPTH_8) |=>
        x_data_reg[7:0] == $past(buf_data[11:4]))
        else $error("8-bit mode did not keep the top bits.");
    a_beat_advance: assert property (
        advance |=> valid_reg && (cnt_reg == $past(cnt_reg) + 1'b1))
        else $error("Beat did not advance by one.");

    c_line_full: cover property ($fell(valid_reg) && !binning_i);
    c_line_binned: cover property ($fell(valid_reg) && (beats_reg ==
                                   BEATS_BIN));
    c_depth10_line: cover property (start &&
                                    (bit_depth_i == ftv_pkg::DEPTH_10));
    c_back_pressure: cover property (beat_valid_i && !beat_ready_o);
endmodule
`default_nettype wire

// File: design/ftv_pkg.sv
// Shared constants and types of the four-tap line video output block.
package ftv_pkg;
    // Width of one converter result.
    localparam int unsigned PIX_W = 12;
    // Number of parallel pixel streams.
    localparam int unsigned TAPS = 4;
    // Width of one four-pixel beat from the readout side.
    localparam int unsigned BEAT_W = 48;
    // Width of the data positions of one serializer (three 8-bit ports).
    localparam int unsigned TX_W = 24;
    // Pixels per full-resolution line on the largest model.
    localparam int unsigned LINE_PIXELS_DEF = 8192;
    // Width of the beat counter, large enough for 8192 / 4.
    localparam int unsigned CNT_W = 12;
    // Depth of the buffer in front of the link.
    localparam int unsigned BUF_DEPTH = 2;
    // Bit depth selection codes.
    localparam logic [1:0] DEPTH_12 = 2'h0;
    localparam logic [1:0] DEPTH_10 = 2'h1;
    localparam logic [1:0] DEPTH_8 = 2'h2;
    // Pixel clock period seen on the link, in ns.
    localparam int unsigned PCLK_PERIOD_NS = 200;
    // Output state machine states.
    typedef enum logic [0:0] {
        FTV_WAIT,
        FTV_LINE
    } ftv_state_t;
endpackage

// File: design/ftv_sync.sv
// Two flip-flop synchroniser for levels entering the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module ftv_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    // First stage, read only by the second stage.
    logic [WIDTH-1:0] meta_reg;
    // Second stage, the synchronised level.
    logic [WIDTH-1:0] sync_reg;

    // Both stages clear under reset and then track the pin.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule
`default_nettype wire

// File: design/ftv_buf.sv
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module ftv_buf #(
    parameter int unsigned WIDTH = 48,
    parameter int unsigned DEPTH = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // Storage words.
    logic [WIDTH-1:0] mem_reg [DEPTH];
    // Write and read pointers.
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    // Number of words held.
    logic [AW:0] fill_reg;
    // Handshake decodes.
    wire logic push = in_valid_i && in_ready_o;
    wire logic pop = out_valid_o && out_ready_i;
    wire logic [AW-1:0] last_ptr = AW'(DEPTH - 1);

    assign in_ready_o = (fill_reg != (AW + 1)'(DEPTH));
    assign out_valid_o = (fill_reg != '0);
    assign out_data_o = mem_reg[rd_ptr_reg];

    // Storage is written on each accepted word.
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // Pointers wrap at the depth; the fill count follows both sides.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == last_ptr) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == last_ptr) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                fill_reg <= fill_reg + 1'b1;
            end else if (pop && !push) begin
                fill_reg <= fill_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/ftv_grabber.sv
// Frame grabber model that captures beats from the two serializer inputs.
`timescale 1ns/1ps
`default_nettype none
module ftv_grabber (
    input wire logic rst_i,
    input wire logic strobe_i,
    input wire logic [23:0] x_data_i,
    input wire logic [23:0] y_data_i,
    input wire logic x_lval_i,
    input wire logic x_dval_i,
    input wire logic x_fval_i,
    input wire logic x_spare_i,
    input wire logic y_lval_i,
    input wire logic y_dval_i,
    input wire logic y_fval_i,
    input wire logic y_spare_i
);
    // Captured beats, second serializer above the first.
    logic [47:0] words [$];
    // Beat counts of finished lines.
    int lines [$];
    // Count of faults seen on flags and idle data.
    int faults = 0;
    // Beats seen so far in the running line.
    int cur = 0;
    // A beat counts only when both flags are high.
    wire logic in_line = x_lval_i & x_dval_i;

    ////////////////////////////////////////////////////////////////////////
    // Reset drops a partial line so that it is never counted as finished.
    always @(posedge rst_i) begin
        cur = 0;
    end

    // Sampling on the falling strobe keeps clear of the launch skew.
    always @(negedge strobe_i) begin
        if (rst_i !== 1'b1) begin
            // Both serializers carry the same flags, frame and spare idle.
            if (x_lval_i !== x_dval_i || y_lval_i !== x_lval_i ||
                y_dval_i !== x_dval_i)
                faults++;
            if ({x_fval_i, x_spare_i, y_fval_i, y_spare_i} !== 4'h0)
                faults++;
            if (in_line === 1'b1) begin
                words.push_back({y_data_i, x_data_i});
                cur++;
            end else begin
                // Outside a line the data lines are ignored but must be low.
                if ({y_data_i, x_data_i} !== 48'h0)
                    faults++;
                if (cur != 0)
                    lines.push_back(cur);
                cur = 0;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/four_tap_line_scan_video_output_tb.sv
// Self-checking bench of the four-tap line video formatter.
`timescale 1ns/1ps
`default_nettype none
module four_tap_line_scan_video_output_tb;
    // Short line keeps the run brief; all counts derive from it.
    localparam int LINE_PIX = 16;
    // Ceiling of clock cycles before the run is cut short.
    localparam int LIMIT = 20000;
    // One ordinary case: depth code, binning and beats per line.
    typedef struct { logic [1:0] depth; logic bin; int beats; } ftv_row_t;
    ftv_row_t rows [6] = '{
        '{ftv_pkg::DEPTH_12, 1'b0, LINE_PIX / 4},
        '{ftv_pkg::DEPTH_10, 1'b0, LINE_PIX / 4},
        '{ftv_pkg::DEPTH_8, 1'b0, LINE_PIX / 4},
        '{2'h3, 1'b0, LINE_PIX / 4},
        '{ftv_pkg::DEPTH_12, 1'b1, LINE_PIX / 8},
        '{ftv_pkg::DEPTH_8, 1'b1, LINE_PIX / 8}};
    logic clk_sys_i, rst_i, pclk_i, readout_done_i, binning_i;
    logic [1:0] bit_depth_i;
    logic beat_valid_i, beat_ready_o, underrun_o;
    logic [47:0] beat_data_i;
    logic [23:0] tx_x_data_o, tx_y_data_o;
    logic tx_x_lval_o, tx_x_fval_o, tx_x_dval_o, tx_x_spare_o, tx_x_strobe_o;
    logic tx_y_lval_o, tx_y_fval_o, tx_y_dval_o, tx_y_spare_o, tx_y_strobe_o;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////
    // Design under test and the grabber model on its link side.
    ftv_video_out #(.LINE_PIXELS(LINE_PIX)) DUT (.clk_sys_i, .rst_i,
        .pclk_i, .readout_done_i, .bit_depth_i, .binning_i, .beat_valid_i,
        .beat_ready_o, .beat_data_i, .tx_x_data_o, .tx_x_lval_o,
        .tx_x_fval_o, .tx_x_dval_o, .tx_x_spare_o, .tx_x_strobe_o,
        .tx_y_data_o, .tx_y_lval_o, .tx_y_fval_o, .tx_y_dval_o,
        .tx_y_spare_o, .tx_y_strobe_o, .underrun_o);
    ftv_grabber grab (.rst_i, .strobe_i(tx_x_strobe_o),
        .x_data_i(tx_x_data_o), .y_data_i(tx_y_data_o),
        .x_lval_i(tx_x_lval_o), .x_dval_i(tx_x_dval_o),
        .x_fval_i(tx_x_fval_o), .x_spare_i(tx_x_spare_o),
        .y_lval_i(tx_y_lval_o), .y_dval_i(tx_y_dval_o),
        .y_fval_i(tx_y_fval_o), .y_spare_i(tx_y_spare_o));

    ////////////////////////////////////////////////////////////////////////
    // System clock at 40 MHz.
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // Free-running pixel clock at 200 ns, offset from the system clock.
    initial begin
        pclk_i = 1'b0;
        #7;
        forever #100 pclk_i = ~pclk_i;
    end

    // Hang guard: counts as a mismatch and closes the run.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel value of pixel p (from 1) of line l.
    function automatic logic [11:0] pix(int l, int p);
        return 12'(p * 12'h0D3 + l * 12'h15B) ^ 12'hA50;
    endfunction

    // Beat k of line l: stream zero in the low bits holds pixel 4k+1.
    function automatic logic [47:0] beat(int l, int k);
        return {pix(l, 4 * k + 4), pix(l, 4 * k + 3),
                pix(l, 4 * k + 2), pix(l, 4 * k + 1)};
    endfunction

    // Expected link word, second serializer above the first.
    function automatic logic [47:0] fmt(logic [1:0] d, logic [47:0] b);
        logic [11:0] s [4];
        logic [9:0] t [4];
        logic [7:0] e [4];
        for (int i = 0; i < 4; i++) begin
            s[i] = b[12 * i +: 12];
            t[i] = s[i][11:2];
            e[i] = s[i][11:4];
        end
        if (d == ftv_pkg::DEPTH_10)
            return {2'h0, t[3][9:8], 2'h0, t[2][9:8], t[2][7:0], t[3][7:0],
                    t[1][7:0], 2'h0, t[1][9:8], 2'h0, t[0][9:8], t[0][7:0]};
        if (d == ftv_pkg::DEPTH_8)
            return {16'h0000, e[3], e[2], e[1], e[0]};
        return {s[3][11:8], s[2][11:8], s[2][7:0], s[3][7:0],
                s[1][7:0], s[1][11:8], s[0][11:8], s[0][7:0]};
    endfunction

    // Compares one value and reports a mismatch at once.
    task automatic check(logic [47:0] got, logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Offers one beat and holds it until the buffer takes it.
    task automatic push(int l, int k);
        logic rdy;
        @(negedge clk_sys_i);
        beat_valid_i = 1'b1;
        beat_data_i = beat(l, k);
        do begin
            #1 rdy = beat_ready_o;
            @(posedge clk_sys_i);
        end while (rdy !== 1'b1);
        @(negedge clk_sys_i);
        beat_valid_i = 1'b0;
    endtask

    // One-cycle readout completion pulse.
    task automatic pulse();
        @(negedge clk_sys_i);
        readout_done_i = 1'b1;
        @(negedge clk_sys_i);
        readout_done_i = 1'b0;
    endtask

    // Outputs low and the buffer open while reset is held.
    task automatic reset_check();
        check({tx_y_data_o, tx_x_data_o}, 48'h0);
        check(48'({beat_ready_o, tx_x_lval_o,
                   tx_x_dval_o, tx_x_strobe_o, tx_y_lval_o, underrun_o}), 48'h20);
    endtask

    // Sends one line; pre beats are buffered before readout completes.
    task automatic run_line(int l, ftv_row_t r, int pre);
        int base;
        int nl;
        int len;
        logic [47:0] want;
        base = grab.words.size();
        nl = grab.lines.size();
        @(negedge clk_sys_i);
        bit_depth_i = r.depth;
        binning_i = r.bin;
        for (int k = 0; k < pre; k++)
            push(l, k);
        if (pre > 1) begin
            // Full buffer refuses and nothing leaves before readout ends.
            repeat (60) @(negedge clk_sys_i);
            check(48'(beat_ready_o), 48'h0);
            check(48'({tx_x_lval_o, tx_x_dval_o}), 48'h0);
            check(48'(grab.words.size() - base), 48'h0);
        end
        pulse();
        for (int k = pre; k < r.beats; k++)
            push(l, k);
        // Both serializers must carry the same pixel clock throughout.
        for (int i = 0; i < 600 && grab.lines.size() <= nl; i++) begin
            @(negedge clk_sys_i);
            check(48'(tx_y_strobe_o), 48'(tx_x_strobe_o));
        end
        len = (grab.lines.size() > nl) ? grab.lines[nl] : 0;
        check(48'(len), 48'(r.beats));
        for (int k = 0; k < r.beats; k++) begin
            want = fmt(r.depth, beat(l, k));
            check(grab.words[base + k], want);
        end
        check(48'(grab.faults), 48'h0);
        check(48'(underrun_o), 48'h0);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, table of cases, then the awkward cases.
    initial begin
        rst_i = 1'b1;
        readout_done_i = 1'b0;
        bit_depth_i = 2'h0;
        binning_i = 1'b0;
        beat_valid_i = 1'b0;
        beat_data_i = 48'h0;
        repeat (8) @(negedge clk_sys_i);
        reset_check();
        rst_i = 1'b0;
        for (int i = 0; i < 6; i++)
            run_line(i, rows[i], 1);
        run_line(6, rows[1], 2);
        // Reset in mid-line, then a clean line afterwards.
        push(7, 0);
        pulse();
        for (int i = 0; i < 600 && tx_x_lval_o !== 1'b1; i++)
            @(posedge clk_sys_i);
        // One beat for a four-beat line leaves the next launch empty.
        repeat (12) @(negedge clk_sys_i);
        check(48'(underrun_o), 48'h1);
        @(negedge clk_sys_i);
        rst_i = 1'b1;
        @(negedge clk_sys_i);
        reset_check();
        repeat (8) @(negedge clk_sys_i);
        rst_i = 1'b0;
        run_line(8, rows[0], 1);
        give_verdict();
    end
endmodule
`default_nettype wire
